// ===== common/wdc_defines.svh
// Constants of the watchdog down-counter block: offsets, fields, resets, timing.
// Assumes it is included by bare name from the package and the design modules.
`ifndef WDC_DEFINES_SVH
`define WDC_DEFINES_SVH

// Bus geometry.
`define WDC_ADR_W      8
`define WDC_DAT_W      32

// Register byte offsets.
`define WDC_OFF_CTRL   8'hD8
`define WDC_OFF_STAT   8'hDC
`define WDC_OFF_MASK   8'hE0

// Control and count register layout and reset value.
`define WDC_CTRL_RESET 8'hFE
`define WDC_BIT_C      0
`define WDC_BIT_SWRST  1
`define WDC_T_W        6

// Event bits of the status and mask registers.
`define WDC_EV_N       3
`define WDC_EV_WDG     0
`define WDC_EV_SWR     1
`define WDC_EV_WRAP    2

// Clock rate and timing.
`define WDC_CLK_HZ     25000000
`define WDC_TICK_DIV   12
`define WDC_RSTPIN_NS  200
`define WDC_RSTPIN_CYC ((`WDC_RSTPIN_NS * (`WDC_CLK_HZ / 1000000)) / 1000)

`endif

// ===== common/wdc_pkg.sv
// Types and helpers of the watchdog down-counter block.
// Assumes wdc_defines.svh is on the include path.
`include "wdc_defines.svh"

package wdc_pkg;

   // Seven-bit physical counter: bit 6 is the software reset bit.
   typedef logic [`WDC_T_W:0] wdc_cnt_t;

   // States of the reset pin pulse generator.
   typedef enum logic [0:0] {
      WDC_PIN_IDLE  = 1'b0,
      WDC_PIN_PULSE = 1'b1
   } wdc_pin_e;

   // Converts a register byte into the physical counter, undoing the bit reversal.
   function automatic wdc_cnt_t reg2cnt(input logic [7:0] r);
      wdc_cnt_t c;
      c = '0;
      for (int i = 0; i < `WDC_T_W; i++) begin
         c[i] = r[7 - i];
      end
      c[`WDC_T_W] = r[`WDC_BIT_SWRST];
      return c;
   endfunction

endpackage

// ===== common/wdc_tick_if.sv
// Carrier of the divided timebase enable between the divider and the watchdog core.
// Assumes both ends run on the same sys_clk.
`timescale 1ns/10ps

interface wdc_tick_if;
   logic tick;

   // The divider drives the enable, the core consumes it.
   modport src (output tick);
   modport dst (input  tick);
endinterface

// ===== src/wdc_tick_div.sv
// Clock divider that gives one enable pulse every DIV cycles of sys_clk.
// Assumes a synchronous active-low reset on the same clock.
`timescale 1ns/10ps
`include "wdc_defines.svh"

module wdc_tick_div #(
   parameter int DIV = `WDC_TICK_DIV
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_n,
   // Timebase enable out.
   wdc_tick_if.src  tickIf
);

   localparam int CW = $clog2(DIV);

   logic [CW-1:0] divCnt_r;
   logic          tick_r;

   // Counts DIV cycles and raises the enable on the last one.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         divCnt_r <= '0;
         tick_r   <= 1'b0;
      end else if (divCnt_r == CW'(DIV - 1)) begin
         divCnt_r <= '0;
         tick_r   <= 1'b1;
      end else begin
         divCnt_r <= divCnt_r + 1'b1;
         tick_r   <= 1'b0;
      end
   end

   assign tickIf.tick = tick_r;

endmodule

// ===== src/wdc_watchdog.sv
// Watchdog down-counter with a classic Wishbone register slave and interrupt.
// Assumes a 25 MHz sys_clk, a synchronous active-low reset, and that
// devResetReq is routed by the system into the device reset.
`timescale 1ns/10ps
`include "wdc_defines.svh"

// How it works
// - The control and count register sits at byte 0xD8, readable and writable.
// - Any reset loads the register with 0xFE in software mode, 0xFF in hardware mode: counter and software reset bits one, C zero unless forced.
// - Counter bits land reversed in register bits 7..2, bit 7 the LSB.
// - Writing the software reset bit zero while active raises a device reset.
// - With the watchdog inactive the software reset bit tops a 7-bit timer.
// - The hardware option forces the activation bit to one, writes ignored.
// - In software mode setting C activates it until the next reset.
// - A non-volatile option input selects software (0) or hardware (1) mode.
// - The counter steps on the internal clock divided by twelve.
// - An active counter running out without refresh raises a device reset.
// - A watchdog reset drives the reset pin low for a brief pulse only.
module wdc_watchdog #(
   parameter int TICK_DIV   = `WDC_TICK_DIV,
   parameter int RSTPIN_CYC = `WDC_RSTPIN_CYC
) (
   // Clock and reset.
   input  wire logic                  sys_clk,
   input  wire logic                  rst_n,
   // Wishbone classic slave.
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [`WDC_ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [`WDC_DAT_W-1:0] wb_dat_i,
   output      logic [`WDC_DAT_W-1:0] wb_dat_o,
   output      logic                  wb_ack_o,
   // Non-volatile option strap.
   input  wire logic                  hardwareWatchdogOption,
   // Reset request and open-drain reset pin.
   output      logic                  devResetReq,
   output      logic                  resetPinOut,
   output      logic                  resetPinOen,
   // Interrupt.
   output      logic                  irq
);

   localparam logic [7:0] RST_BYTE = `WDC_CTRL_RESET;
   localparam int         PCW      = $clog2(RSTPIN_CYC + 1);
   // Word indices of the three registers on the byte address bus.
   localparam logic [5:0] CTRL_WORD = 6'(`WDC_OFF_CTRL >> 2);
   localparam logic [5:0] STAT_WORD = 6'(`WDC_OFF_STAT >> 2);
   localparam logic [5:0] MASK_WORD = 6'(`WDC_OFF_MASK >> 2);

   wdc_tick_if tickIf ();

   logic [`WDC_T_W-1:0]   tCnt_r;
   logic                  softwareResetBit_r;
   logic                  cSet_r;
   logic                  cActive;
   logic [7:0]            ctrlView;
   logic                  optMeta_r;
   logic                  optSync_r;
   logic                  hwOpt_r;
   logic                  busAck_r;
   logic [5:0]            adrWord;
   logic [`WDC_DAT_W-1:0] datO_r;
   logic                  req;
   logic                  ctrlWr;
   logic                  statRd;
   logic                  maskWr;
   logic [7:0]            wrByte;
   logic                  tick;
   logic                  endCount;
   logic                  swReset;
   logic                  wrapEv;
   logic                  wdgFire;
   logic [`WDC_EV_N-1:0]  events;
   logic [`WDC_EV_N-1:0]  stat_r;
   logic [`WDC_EV_N-1:0]  mask_r;
   logic                  devReset_r;
   wdc_pkg::wdc_pin_e     pinState_r;
   logic [PCW-1:0]        pinCnt_r;
   wdc_pkg::wdc_cnt_t     cnt7;
   wdc_pkg::wdc_cnt_t     rstCnt;

   // Divided timebase for the counter.
   wdc_tick_div #(
      .DIV     (TICK_DIV)
   ) u_div (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .tickIf  (tickIf)
   );

   assign tick   = tickIf.tick;
   assign cnt7   = {softwareResetBit_r, tCnt_r};
   assign rstCnt = wdc_pkg::reg2cnt(RST_BYTE);

   // Bus decode: one request per access, answered by a registered ack.
   assign req     = wb_cyc_i && wb_stb_i && !busAck_r;
   assign adrWord = wb_adr_i[`WDC_ADR_W-1:2];
   assign wrByte  = wb_dat_i[7:0];
   assign ctrlWr  = req && wb_we_i && wb_sel_i[0] && (adrWord == CTRL_WORD);
   assign maskWr  = req && wb_we_i && wb_sel_i[0] && (adrWord == MASK_WORD);
   assign statRd  = req && !wb_we_i && (adrWord == STAT_WORD);

   // Two-stage synchroniser for the option strap pin.
   always_ff @(posedge sys_clk) begin
      optMeta_r <= hardwareWatchdogOption;
      optSync_r <= optMeta_r;
   end

   // The option is caught while reset is held and kept until the next one.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         hwOpt_r <= optSync_r;
      end
   end

   // Activation: the hardware option forces it, software may only set it.
   assign cActive = cSet_r || hwOpt_r;

   always_ff @(posedge sys_clk) begin
      if (!rst_n || wdgFire) begin
         cSet_r <= RST_BYTE[`WDC_BIT_C];
      end else if (ctrlWr && wrByte[`WDC_BIT_C]) begin
         cSet_r <= 1'b1;
      end
   end

   // Reset causes: running out while active, or a software reset write.
   assign endCount = cActive && tick && !ctrlWr && (tCnt_r == '0);
   assign swReset  = ctrlWr && !wrByte[`WDC_BIT_SWRST]
                     && (cActive || wrByte[`WDC_BIT_C]);
   assign wrapEv   = !cActive && tick && !ctrlWr && (cnt7 == '0);
   assign wdgFire  = endCount || swReset;
   assign events   = {wrapEv, swReset, endCount};

   // Counter: a write reloads it, otherwise it counts down on each tick.
   always_ff @(posedge sys_clk) begin
      if (!rst_n || wdgFire) begin
         {softwareResetBit_r, tCnt_r} <= rstCnt;
      end else if (ctrlWr) begin
         {softwareResetBit_r, tCnt_r} <= wdc_pkg::reg2cnt(wrByte);
      end else if (tick && cActive) begin
         tCnt_r <= tCnt_r - 1'b1;
      end else if (tick) begin
         {softwareResetBit_r, tCnt_r} <= cnt7 - 1'b1;
      end
   end

   // Register view: counter bits reversed into bits 7..2.
   genvar gi;
   generate
      for (gi = 0; gi < `WDC_T_W; gi++) begin : g_rev
         assign ctrlView[7 - gi] = tCnt_r[gi];
      end
   endgenerate
   assign ctrlView[`WDC_BIT_SWRST] = softwareResetBit_r;
   assign ctrlView[`WDC_BIT_C]     = cActive;

   // Bus answer: ack one cycle after the request, data captured with it.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         busAck_r <= 1'b0;
      end else begin
         busAck_r <= req;
      end
   end

   // Read multiplexer; unmapped addresses read as zero.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         datO_r <= '0;
      end else if (req && !wb_we_i) begin
         case (adrWord)
            CTRL_WORD: datO_r <= {{(`WDC_DAT_W - 8){1'b0}}, ctrlView};
            STAT_WORD: datO_r <= {{(`WDC_DAT_W - `WDC_EV_N){1'b0}}, stat_r};
            MASK_WORD: datO_r <= {{(`WDC_DAT_W - `WDC_EV_N){1'b0}}, mask_r};
            default:   datO_r <= '0;
         endcase
      end
   end

   assign wb_ack_o = busAck_r;
   assign wb_dat_o = datO_r;

   // Sticky status: a read clears it, but a new event in that cycle wins.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         stat_r <= '0;
      end else if (statRd) begin
         stat_r <= events;
      end else begin
         stat_r <= stat_r | events;
      end
   end

   // Interrupt mask.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mask_r <= '0;
      end else if (maskWr) begin
         mask_r <= wrByte[`WDC_EV_N-1:0];
      end
   end

   assign irq = |(stat_r & mask_r);

   // One-cycle device reset request after a watchdog or software reset.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         devReset_r <= 1'b0;
      end else begin
         devReset_r <= wdgFire;
      end
   end

   assign devResetReq = devReset_r;

   // Reset pin pulse: a short low drive that only flags the reset phase.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pinState_r <= wdc_pkg::WDC_PIN_IDLE;
         pinCnt_r   <= '0;
      end else begin
         case (pinState_r)
            wdc_pkg::WDC_PIN_IDLE: begin
               if (wdgFire) begin
                  pinState_r <= wdc_pkg::WDC_PIN_PULSE;
                  pinCnt_r   <= PCW'(RSTPIN_CYC - 1);
               end
            end
            wdc_pkg::WDC_PIN_PULSE: begin
               if (pinCnt_r == '0) begin
                  pinState_r <= wdc_pkg::WDC_PIN_IDLE;
               end else begin
                  pinCnt_r <= pinCnt_r - 1'b1;
               end
            end
            default: begin
               pinState_r <= wdc_pkg::WDC_PIN_IDLE;
               pinCnt_r   <= '0;
            end
         endcase
      end
   end

   // Open drain: only ever drives low, enable low while driving.
   assign resetPinOut = 1'b0;
   assign resetPinOen = (pinState_r != wdc_pkg::WDC_PIN_PULSE);

   // Checks on the block's own behaviour.
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_expire;
      cActive && tick && !ctrlWr && (tCnt_r == '0);
   endsequence

   sequence s_pin_pulse;
      devResetReq && !resetPinOen ##1 !resetPinOen [*4] ##1 resetPinOen;
   endsequence

   AST_CTRL_READ: assert property (
      req && !wb_we_i && (wb_adr_i == `WDC_OFF_CTRL)
      |=> wb_ack_o && (wb_dat_o[7:0] == $past(ctrlView)))
      else $error("Control register read returned wrong data.");

   AST_RESET_VALUE: assert property (
      $rose(rst_n) |-> (ctrlView[7:1] == RST_BYTE[7:1]))
      else $error("Register not at reset value after reset.");

   AST_REFRESH_MAP: assert property (
      ctrlWr && !wdgFire |=> (ctrlView[7:1] == $past(wrByte[7:1])))
      else $error("Written counter bits not read back in place.");

   AST_SW_RESET: assert property (
      ctrlWr && cActive && !wrByte[`WDC_BIT_SWRST] |=> devResetReq ##1 !devResetReq)
      else $error("Software reset write gave no single reset pulse.");

   AST_TIMER7: assert property (
      !cActive && tick && !ctrlWr |=> (cnt7 == $past(cnt7) - 1'b1))
      else $error("Inactive counter did not step as a 7-bit timer.");

   AST_HW_FORCE: assert property (
      hwOpt_r && req && !wb_we_i && (adrWord == CTRL_WORD) |=> wb_dat_o[`WDC_BIT_C])
      else $error("Hardware option does not hold the activation bit.");

   AST_STAY_ACTIVE: assert property (
      cActive && !wdgFire |=> cActive)
      else $error("Watchdog deactivated without a reset.");

   AST_TICK_RATE: assert property (
      tick |=> !tick [*8] ##1 !tick [*3] ##1 tick)
      else $error("Timebase enable not one in twelve cycles.");

   AST_EXPIRE: assert property (
      s_expire |=> devResetReq && !resetPinOen)
      else $error("Counter ran out without a reset.");

   AST_PIN_PULSE: assert property (
      $rose(devResetReq) |-> s_pin_pulse)
      else $error("Reset pin pulse not five cycles long.");

endmodule

// ===== tb/tb_wdc.sv
// Self-checking bench of the watchdog down-counter block.
// Assumes wdc_defines.svh is on the include path and the design files are compiled first.
`timescale 1ns/10ps

module tb;
   // Clock, reset, bus and strap drivers.
   logic        sysClk = 1'b0;
   logic        rstN   = 1'b0;
   logic        wbCyc  = 1'b0;
   logic        wbStb  = 1'b0;
   logic        wbWe   = 1'b0;
   logic [7:0]  wbAdr  = 8'h00;
   logic [31:0] wbDatI = 32'h0;
   logic [3:0]  wbSel  = 4'h0;
   logic        hwOpt  = 1'b0;
   // Design outputs.
   logic [31:0] wbDatO;
   logic        wbAck;
   logic        devReq;
   logic        pinOut;
   logic        pinOen;
   logic        irq;
   // Bookkeeping.
   int          n_fail = 0;
   int          checks = 0;
   int          nRst   = 0;
   int          pinLow = 0;
   int          p0;
   int          n;
   logic [31:0] rd;

   // Free-running 25 MHz clock.
   always #20 sysClk = ~sysClk;

   wdc_watchdog #(.TICK_DIV(12), .RSTPIN_CYC(5)) dut (
      .sys_clk(sysClk), .rst_n(rstN), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
      .wb_ack_o(wbAck), .hardwareWatchdogOption(hwOpt), .devResetReq(devReq),
      .resetPinOut(pinOut), .resetPinOen(pinOen), .irq(irq));

   // Counts reset requests and cycles with the reset pin driven low.
   always @(posedge sysClk) begin
      if (devReq === 1'b1) nRst <= nRst + 1;
      if (pinOen === 1'b0) pinLow <= pinLow + 1;
   end

   // Builds the register view of a 7-bit count: bits 7..2 reversed, bit 1 the top bit.
   function automatic logic [7:0] enc(input logic [6:0] c, input logic cb);
      logic [7:0] r;
      for (int i = 0; i < 6; i++) r[7-i] = c[i];
      r[1] = c[6];
      r[0] = cb;
      return r;
   endfunction

   // Compares a seen value with the expected one and counts a mismatch.
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] want);
      checks++;
      if (got !== want) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, want, got);
      end
   endtask

   // One classic Wishbone cycle, held until ack is sampled high; only the
   // bench watchdog ends a wait for an answer that never comes.
   task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
      @(posedge sysClk);
      wbCyc  <= 1'b1;
      wbStb  <= 1'b1;
      wbWe   <= we;
      wbAdr  <= a;
      wbSel  <= 4'h1;
      wbDatI <= {24'h0, d};
      do begin
         @(posedge sysClk);
      end while (wbAck !== 1'b1);
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe  <= 1'b0;
      wbSel <= 4'h0;
   endtask

   // Waits a bounded number of edges for a reset request.
   task automatic wait_rst(output int k);
      k = 0;
      while (devReq !== 1'b1 && k < 80) begin
         @(posedge sysClk);
         k++;
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Cuts a hang short.
   initial begin
      #(40 * 6000);
      n_fail++;
      print_verdict();
   end

   // Main test sequence.
   initial begin
      repeat (10) @(posedge sysClk);
      rstN <= 1'b1;
      wb(1'b0, 8'hD8, 8'h00);
      chk("ctrl_reset", rd, 32'hFE);
      wb(1'b0, 8'hDC, 8'h00);
      chk("status_reset", rd, 32'h0);
      wb(1'b0, 8'hE0, 8'h00);
      chk("mask_reset", rd, 32'h0);
      wb(1'b0, 8'h40, 8'h00);
      chk("unmapped_read", rd, 32'h0);
      chk("irq_reset", {31'h0, irq}, 32'h0);
      // Reload with an asymmetric count and read it back reversed before the next step.
      wb(1'b1, 8'hD8, enc(7'h25, 1'b0));
      wb(1'b0, 8'hD8, 8'h00);
      chk("ctrl_reload", rd, {24'h0, enc(7'h25, 1'b0)});
      // Inactive 7-bit timer runs through zero and wraps with no reset.
      wb(1'b1, 8'hE0, 8'h04);
      wb(1'b1, 8'hD8, enc(7'h01, 1'b0));
      repeat (30) @(posedge sysClk);
      chk("irq_wrap", {31'h0, irq}, 32'h1);
      wb(1'b0, 8'hDC, 8'h00);
      chk("status_wrap", rd & 32'h4, 32'h4);
      chk("no_reset_inactive", nRst, 0);
      @(posedge sysClk);
      chk("irq_cleared", {31'h0, irq}, 32'h0);
      // Activate, try to deactivate, then request a software reset.
      wb(1'b1, 8'hD8, 8'hFF);
      wb(1'b1, 8'hD8, 8'hFE);
      wb(1'b0, 8'hD8, 8'h00);
      chk("ctrl_sticky", {31'h0, rd[0]}, 32'h1);
      chk("no_reset_bit_one", nRst, 0);
      p0 = pinLow;
      wb(1'b1, 8'hD8, 8'hFC);
      chk("pin_level", {31'h0, pinOut}, 32'h0);
      repeat (10) @(posedge sysClk);
      chk("sw_reset", nRst, 1);
      chk("pin_pulse_sw", pinLow - p0, 5);
      wb(1'b0, 8'hD8, 8'h00);
      chk("ctrl_after_sw", {31'h0, rd[0]}, 32'h0);
      wb(1'b0, 8'hDC, 8'h00);
      chk("status_sw", rd & 32'h3, 32'h2);
      // Active watchdog refreshed in time, then left to expire.
      wb(1'b1, 8'hD8, 8'hC3);
      repeat (10) begin
         repeat (18) @(posedge sysClk);
         wb(1'b1, 8'hD8, 8'hC3);
      end
      chk("refresh_holds", nRst, 1);
      p0 = pinLow;
      wait_rst(n);
      // A count of three runs out on the fourth step of twelve cycles, first step 1 to 12 away.
      chk("expiry_time", {31'h0, (n >= 37 && n <= 48)}, 32'h1);
      repeat (8) @(posedge sysClk);
      chk("pin_pulse_wdg", pinLow - p0, 5);
      chk("irq_masked", {31'h0, irq}, 32'h0);
      wb(1'b1, 8'hE0, 8'h01);
      chk("irq_unmasked", {31'h0, irq}, 32'h1);
      wb(1'b0, 8'hDC, 8'h00);
      chk("status_wdg", rd & 32'h3, 32'h1);
      @(posedge sysClk);
      chk("irq_read_clear", {31'h0, irq}, 32'h0);
      // Hardware option: activation bit forced high and not writable.
      hwOpt <= 1'b1;
      rstN  <= 1'b0;
      repeat (10) @(posedge sysClk);
      rstN <= 1'b1;
      wb(1'b0, 8'hD8, 8'h00);
      chk("ctrl_hw_reset", rd, 32'hFF);
      wb(1'b1, 8'hD8, 8'hFE);
      wb(1'b0, 8'hD8, 8'h00);
      chk("ctrl_hw_forced", {31'h0, rd[0]}, 32'h1);
      print_verdict();
   end
endmodule
